/* File: core/sst_core.sv */
`timescale 1ns/1ps

// Notes on behaviour
// - Reference period off by over thirty percent or missing sets oscillator fault and diagnostics.
// - A four-bit up-counter with one slot per count triggers the self-tests.
// - Global enable bit turns the slot sequencer and the five triggered tests on or off.
// - Each test also needs its own non-volatile enable input.
// - Ready clears the start trigger; a trigger left at slot end forces diagnostics.
// - Field conversion compares two temperatures; a difference above the tolerance fails unless disabled.
// - Main plus inverted angle must equal the clamp level sum.
// - Test division must return the known expected quotient.
// - Main rotation angle plus inverted rotation angle must be zero.
// - Zero-corrected angle must equal its redundant copy.
// - Checks six to twelve always run; each flag has its own mask.
// - Control signal check flags incomplete datapath processing.
// - Completion check flags any failed test by the end of the round.
// - Sequencer state carries parity; mismatch raises the encoding flag.
// - Converter result above ninety-five percent of full scale sets overflow flag.
// - Pre-rotation adder overflow sets the adder flag.
// - Rotation block overflow sets the rotation flag.
// - Clamp switch seen before range position sets angular range flag.
// - Each check owns one flag bit, field conversion at bit zero upwards.
module sst_core (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic osc_ref,
   input wire logic [4:0] nvm_test_enable,
   input wire logic [4:0] test_ready,
   input wire logic [11:0] temp_sensor,
   input wire logic [11:0] temp_from_amplitude,
   input wire logic [15:0] angle_main,
   input wire logic [15:0] angle_inverted,
   input wire logic [15:0] clamp_level_sum,
   input wire logic [15:0] division_result,
   input wire logic [15:0] rotation_main,
   input wire logic [15:0] rotation_inverted,
   input wire logic [15:0] zero_angle,
   input wire logic [15:0] zero_angle_redundant,
   input wire logic control_error,
   input wire logic [15:0] converter_result,
   input wire logic adder_overflow,
   input wire logic rotation_overflow,
   input wire logic measure_start,
   input wire logic range_position_seen,
   input wire logic clamp_switch_seen,
   output logic [4:0] test_start,
   output logic diag_mode
);

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   logic [12:0] settings;
   logic inject_parity;
   logic osc_fault;
   logic clear_fault;
   logic [11:0] flags;
   logic [3:0] seq_count;
   logic seq_parity;
   logic aw_ok;
   logic w_ok;
   logic [7:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic do_write;
   logic [31:0] next_rdata;
   logic read_hit;
   logic slot_tick;

   logic global_en;
   logic [4:0] test_en;
   logic [6:0] fixed_mask;
   assign global_en = settings[sst_pkg::SET_GLOBAL_EN];
   assign test_en = {5{global_en}} & nvm_test_enable & ~settings[sst_pkg::SET_MASK_LSB-1:sst_pkg::SET_DISABLE_LSB];
   assign fixed_mask = settings[sst_pkg::SET_WIDTH-1:sst_pkg::SET_MASK_LSB];

   // ----------------------------------------
   // Bus write side
   // ----------------------------------------
   assign do_write = aw_ok && w_ok && !s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         aw_ok <= 1'b0;
         aw_addr_q <= 8'h00;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         aw_ok <= 1'b1;
         aw_addr_q <= s_axi_awaddr;
      end else if (do_write) begin
         aw_ok <= 1'b0;
      end else if (!aw_ok && !s_axi_bvalid) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_wready <= 1'b0;
         w_ok <= 1'b0;
         w_data_q <= 32'h0000_0000;
         w_strb_q <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         w_ok <= 1'b1;
         w_data_q <= s_axi_wdata;
         w_strb_q <= s_axi_wstrb;
      end else if (do_write) begin
         w_ok <= 1'b0;
      end else if (!w_ok && !s_axi_bvalid) begin
         s_axi_wready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= sst_pkg::RESP_OKAY;
      end else if (do_write) begin
         s_axi_bvalid <= 1'b1;
         if (aw_addr_q == sst_pkg::ADDR_SETTINGS || aw_addr_q == sst_pkg::ADDR_CONTROL_ONE) begin
            s_axi_bresp <= sst_pkg::RESP_OKAY;
         end else begin
            s_axi_bresp <= sst_pkg::RESP_SLVERR;
         end
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         settings <= sst_pkg::SET_RESET;
      end else if (do_write && aw_addr_q == sst_pkg::ADDR_SETTINGS) begin
         if (w_strb_q[0]) begin
            settings[7:0] <= w_data_q[7:0];
         end
         if (w_strb_q[1]) begin
            settings[12:8] <= w_data_q[12:8];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         inject_parity <= 1'b0;
      end else if (do_write && aw_addr_q == sst_pkg::ADDR_CONTROL_ONE && w_strb_q[0]
                   && w_data_q[sst_pkg::CTL_INJECT]) begin
         inject_parity <= 1'b1;
      end else if (slot_tick) begin
         inject_parity <= 1'b0;
      end
   end

   // ----------------------------------------
   // Bus read side
   // ----------------------------------------
   always_comb begin
      next_rdata = 32'h0000_0000;
      read_hit = 1'b1;
      unique case (s_axi_araddr)
         sst_pkg::ADDR_SETTINGS: next_rdata[12:0] = settings;
         sst_pkg::ADDR_CONTROL_ONE: begin
            next_rdata[sst_pkg::CTL_DIAG] = diag_mode;
            next_rdata[sst_pkg::CTL_INJECT] = inject_parity;
            next_rdata[sst_pkg::CTL_CLEAR_FAULT] = clear_fault;
            next_rdata[sst_pkg::CTL_OSC_FAULT] = osc_fault;
         end
         sst_pkg::ADDR_FLAGS: next_rdata[11:0] = flags;
         sst_pkg::ADDR_SEQ_STATUS: next_rdata[4:0] = {seq_parity, seq_count};
         default: read_hit = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= sst_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= read_hit ? sst_pkg::RESP_OKAY : sst_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end else begin
         s_axi_arready <= 1'b1;
      end
   end

   // ----------------------------------------
   // Oscillator monitor
   // ----------------------------------------
   logic ref_meta;
   logic ref_sync;
   logic ref_last;
   logic ref_armed;
   logic [11:0] ref_cnt;
   logic ref_rise;
   assign ref_rise = ref_sync && !ref_last;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         // Idle high, so a pin held high through reset gives no false edge.
         ref_meta <= 1'b1;
         ref_sync <= 1'b1;
         ref_last <= 1'b1;
      end else begin
         ref_meta <= osc_ref;
         ref_sync <= ref_meta;
         ref_last <= ref_sync;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ref_cnt <= 12'h000;
         ref_armed <= 1'b0;
         osc_fault <= 1'b0;
      end else if (ref_rise) begin
         ref_cnt <= 12'h000;
         ref_armed <= 1'b1;
         if (ref_armed && ref_cnt < 12'(sst_pkg::OSC_LO_CYC)) begin
            osc_fault <= 1'b1;
         end
      end else if (ref_cnt >= 12'(sst_pkg::OSC_HI_CYC)) begin
         osc_fault <= 1'b1;
      end else begin
         ref_cnt <= ref_cnt + 12'h001;
      end
   end

   // ----------------------------------------
   // Slot sequencer
   // ----------------------------------------
   logic [10:0] slot_div;
   logic [3:0] next_count;
   assign next_count = seq_count + 4'h1;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         slot_div <= 11'h000;
         slot_tick <= 1'b0;
      end else if (slot_div == 11'(sst_pkg::SLOT_CYC - 1)) begin
         slot_div <= 11'h000;
         slot_tick <= 1'b1;
      end else begin
         slot_div <= slot_div + 11'h001;
         slot_tick <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         seq_count <= 4'h0;
         seq_parity <= 1'b0;
      end else if (slot_tick && global_en) begin
         seq_count <= next_count;
         seq_parity <= (^next_count) ^ inject_parity;
      end
   end

   // ----------------------------------------
   // Test triggers and results
   // ----------------------------------------
   logic [4:0] test_fail;
   logic round_fail;

   always_comb begin
      test_fail = 5'h00;
      if ((temp_sensor > temp_from_amplitude ? temp_sensor - temp_from_amplitude
           : temp_from_amplitude - temp_sensor) > sst_pkg::TEMP_TOL) begin
         test_fail[0] = 1'b1;
      end
      test_fail[1] = (angle_main + angle_inverted) != clamp_level_sum;
      test_fail[2] = division_result != sst_pkg::DIV_EXPECTED;
      test_fail[3] = (rotation_main + rotation_inverted) != 16'h0000;
      test_fail[4] = zero_angle != zero_angle_redundant;
      test_fail = test_fail & test_start & test_ready;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || !global_en) begin
         test_start <= 5'h00;
      end else begin
         for (int i = 0; i < sst_pkg::NUM_TESTS; i++) begin
            if (slot_tick && next_count == 4'(i + 1)) begin
               test_start[i] <= test_en[i];
            end else if (test_ready[i]) begin
               test_start[i] <= 1'b0;
            end
         end
      end
   end

   // trigger left standing at slot end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clear_fault <= 1'b0;
      end else if (slot_tick && global_en && (test_start & ~test_ready) != 5'h00) begin
         clear_fault <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         round_fail <= 1'b0;
      end else if ((test_fail & test_en) != 5'h00 || clear_fault) begin
         round_fail <= 1'b1;
      end else if (slot_tick && seq_count == sst_pkg::LAST_SLOT) begin
         round_fail <= 1'b0;
      end
   end

   // ----------------------------------------
   // Flag collection
   // ----------------------------------------
   logic [11:0] fail_vec;
   logic [11:0] flag_en;
   logic range_seen;

   // order of clamp and range detections
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         range_seen <= 1'b0;
      end else if (range_position_seen) begin
         range_seen <= 1'b1;
      end else if (measure_start) begin
         range_seen <= 1'b0;
      end
   end

   always_comb begin
      fail_vec = 12'h000;
      fail_vec[4:0] = test_fail;
      fail_vec[sst_pkg::FLAG_CONTROL] = control_error;
      fail_vec[sst_pkg::FLAG_COMPLETION] = slot_tick && seq_count == sst_pkg::LAST_SLOT && round_fail;
      fail_vec[sst_pkg::FLAG_ENCODING] = (^seq_count) != seq_parity;
      fail_vec[sst_pkg::FLAG_CONV_RANGE] = converter_result > sst_pkg::CONV_LIMIT;
      fail_vec[sst_pkg::FLAG_ADDER] = adder_overflow;
      fail_vec[sst_pkg::FLAG_ROTATION] = rotation_overflow;
      fail_vec[sst_pkg::FLAG_ANGULAR] = clamp_switch_seen && !range_seen && !range_position_seen;
   end

   // fixed checks gated by masks only
   assign flag_en = {~fixed_mask, test_en};

   // masked or disabled checks stay clear
   genvar g;
   generate
      for (g = 0; g < sst_pkg::NUM_CHECKS; g++) begin : g_flag
         sst_sticky_flag u_flag (
            .aclk(aclk),
            .aresetn(aresetn),
            .fail(fail_vec[g]),
            .enable(flag_en[g]),
            .flag(flags[g])
         );
      end
   endgenerate

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         diag_mode <= 1'b0;
      end else if (flags != 12'h000 || osc_fault || clear_fault) begin
         diag_mode <= 1'b1;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_left_standing;
      slot_tick && global_en && (test_start & ~test_ready) != 5'h00;
   endsequence

   sequence s_fault_then_diag;
      clear_fault ##1 diag_mode;
   endsequence

   chk_osc_diag: assert property (osc_fault |=> diag_mode)
      else $error("oscillator fault did not force diagnostics");

   chk_slot_advance: assert property (slot_tick && global_en |=> seq_count == $past(next_count))
      else $error("slot counter did not advance");

   chk_global_off: assert property (!global_en |=> test_start == 5'h00)
      else $error("trigger active while unit disabled");

   chk_ready_clear: assert property (
      !slot_tick && (test_start & test_ready) != 5'h00 |=> (test_start & $past(test_start & test_ready)) == 5'h00)
      else $error("ready did not clear trigger");

   chk_timeout_diag: assert property (s_left_standing |=> s_fault_then_diag)
      else $error("standing trigger did not force diagnostics");

   chk_parity_flag: assert property (
      (^seq_count) != seq_parity && !fixed_mask[2] |=> flags[sst_pkg::FLAG_ENCODING] ##1 diag_mode)
      else $error("parity mismatch not flagged");

   chk_conv_flag: assert property (
      converter_result > sst_pkg::CONV_LIMIT && !fixed_mask[3] |=> flags[sst_pkg::FLAG_CONV_RANGE])
      else $error("converter overflow not flagged");

   chk_flags_sticky: assert property ((flags & $past(flags)) == $past(flags))
      else $error("flag cleared before reset");

endmodule

/* File: core/sst_pkg.sv */
package sst_pkg;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] ADDR_SETTINGS = 8'h00;
   localparam logic [7:0] ADDR_CONTROL_ONE = 8'h04;
   localparam logic [7:0] ADDR_FLAGS = 8'h08;
   localparam logic [7:0] ADDR_SEQ_STATUS = 8'h0c;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ----------------------------------------
   // Settings fields
   // ----------------------------------------
   localparam int SET_GLOBAL_EN = 0;
   localparam int SET_DISABLE_LSB = 1;
   localparam int SET_MASK_LSB = 6;
   localparam int SET_WIDTH = 13;
   localparam logic [12:0] SET_RESET = 13'h0001;

   // ----------------------------------------
   // Control register one fields
   // ----------------------------------------
   localparam int CTL_DIAG = 0;
   localparam int CTL_INJECT = 1;
   localparam int CTL_CLEAR_FAULT = 2;
   localparam int CTL_OSC_FAULT = 7;

   // ----------------------------------------
   // Checks and flag bits
   // ----------------------------------------
   localparam int NUM_TESTS = 5;
   localparam int NUM_CHECKS = 12;
   localparam int FLAG_CONTROL = 5;
   localparam int FLAG_COMPLETION = 6;
   localparam int FLAG_ENCODING = 7;
   localparam int FLAG_CONV_RANGE = 8;
   localparam int FLAG_ADDER = 9;
   localparam int FLAG_ROTATION = 10;
   localparam int FLAG_ANGULAR = 11;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int CLK_PERIOD_PS = 5000;
   localparam int SLOT_TIME_NS = 10000;
   localparam int SLOT_CYC = (SLOT_TIME_NS * 1000) / CLK_PERIOD_PS;
   localparam logic [3:0] LAST_SLOT = 4'hf;
   localparam int OSC_REF_CYC = 1000;
   localparam int OSC_TOL_PCT = 30;
   localparam int OSC_LO_CYC = (OSC_REF_CYC * (100 - OSC_TOL_PCT)) / 100;
   localparam int OSC_HI_CYC = (OSC_REF_CYC * (100 + OSC_TOL_PCT) + 99) / 100;

   // ----------------------------------------
   // Datapath limits
   // ----------------------------------------
   localparam logic [15:0] CONV_FULL_SCALE = 16'hffff;
   localparam int CONV_LIMIT_PCT = 95;
   localparam logic [15:0] CONV_LIMIT = 16'((32'(CONV_FULL_SCALE) * CONV_LIMIT_PCT) / 100);
   localparam logic [11:0] TEMP_TOL = 12'h010;
   localparam logic [15:0] DIV_EXPECTED = 16'h1234;

endpackage

/* File: core/sst_sticky_flag.sv */
`timescale 1ns/1ps

module sst_sticky_flag (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic fail,
   input wire logic enable,
   output logic flag
);

   // ----------------------------------------
   // Flag latch held until reset
   // ----------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         flag <= 1'b0;
      end else if (fail && enable) begin
         flag <= 1'b1;
      end
   end

endmodule

/* File: verif/testbench.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin error_cnt++; \
   $display("mismatch %s exp %h got %h", nm, ex, got); end end

module testbench;
   // ----------------------------------------
   // Stimulus signals
   // ----------------------------------------
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic s_axi_arready, s_axi_rvalid, diag_mode;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic osc_ref = 1'b0, control_error = 1'b0, adder_overflow = 1'b0, rotation_overflow = 1'b0;
   logic measure_start = 1'b0, range_position_seen = 1'b0, clamp_switch_seen = 1'b0;
   logic [4:0] nvm_test_enable = 5'h1f, test_ready = 5'h00, test_start, seen = 5'h00;
   logic [11:0] temp_sensor = 12'h0, temp_from_amplitude = 12'h0;
   logic [15:0] angle_main = 16'h0, angle_inverted = 16'hffff, clamp_level_sum = 16'hffff;
   logic [15:0] division_result = 16'h1234, rotation_main = 16'h0, rotation_inverted = 16'h0;
   logic [15:0] zero_angle = 16'h0, zero_angle_redundant = 16'h0, converter_result = 16'h0;
   logic osc_run = 1'b1, ready_off = 1'b0, bad_div = 1'b0;
   int seed = 21951;
   int error_cnt = 0;
   int samples_checked = 0;
   int fix[5] = '{5, 8, 9, 10, 11};

   sst_core u_dut (.*);

   always #2.5 aclk = ~aclk;

   // ----------------------------------------
   // Self-test responder with random operands
   // ----------------------------------------
   always @(posedge aclk) begin
      logic [15:0] r;
      r = 16'($random(seed));
      test_ready <= test_start & ~test_ready & 5'($random(seed)) & {5{~ready_off}};
      temp_sensor <= r[11:0];
      temp_from_amplitude <= r[11:0];
      angle_main <= r;
      angle_inverted <= ~r;
      rotation_main <= r;
      rotation_inverted <= -r;
      zero_angle <= r;
      zero_angle_redundant <= r;
      division_result <= sst_pkg::DIV_EXPECTED ^ {15'h0, bad_div};
      seen <= aresetn ? (seen | test_start) : 5'h00;
   end

   always begin
      repeat (500) @(posedge aclk);
      if (osc_run) osc_ref <= ~osc_ref;
   end

   initial begin
      repeat (90000) @(posedge aclk);
      error_cnt++;
      end_sim();
   end

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic end_sim();
      if (error_cnt == 0 && samples_checked > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   function automatic logic [31:0] seq_word(input logic [3:0] c);
      return {27'h0, ^c, c};
   endfunction

   task automatic rst();
      aresetn <= 1'b0;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bit aw;
      bit w;
      aw = 0;
      w = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw && w)) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin
            aw = 1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w = 1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      `CHK("bresp", sst_pkg::RESP_OKAY, s_axi_bresp)
      s_axi_bready <= 1'b0;
   endtask

   task automatic chkr(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ex, input logic [31:0] m);
      logic [31:0] d;
      logic [1:0] r;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      d = s_axi_rdata;
      r = s_axi_rresp;
      `CHK("rresp", er, r)
      `CHK("rdata", ex, d & m)
   endtask

   task automatic fault(input int k);
      case (k)
         5: control_error <= 1'b1;
         8: converter_result <= sst_pkg::CONV_LIMIT + 16'h1;
         9: adder_overflow <= 1'b1;
         10: rotation_overflow <= 1'b1;
         default: measure_start <= 1'b1;
      endcase
      @(posedge aclk);
      measure_start <= 1'b0;
      clamp_switch_seen <= (k == 11);
      control_error <= 1'b0;
      converter_result <= 16'h0;
      adder_overflow <= 1'b0;
      rotation_overflow <= 1'b0;
      @(posedge aclk);
      clamp_switch_seen <= 1'b0;
      repeat (4) @(posedge aclk);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      logic [31:0] fl;
      rst();
      chkr(sst_pkg::ADDR_SETTINGS, sst_pkg::RESP_OKAY, 32'h1, 32'h1fff);
      chkr(8'h10, sst_pkg::RESP_SLVERR, 32'h0, 32'hffffffff);
      wr(sst_pkg::ADDR_SETTINGS, 32'h0);
      repeat (2500) @(posedge aclk);
      `CHK("seen", 5'h00, seen)
      wr(sst_pkg::ADDR_SETTINGS, 32'h1fc1);
      foreach (fix[i]) fault(fix[i]);
      chkr(sst_pkg::ADDR_FLAGS, sst_pkg::RESP_OKAY, 32'h0, 32'hfff);
      `CHK("diag", 1'b0, diag_mode)
      wr(sst_pkg::ADDR_SETTINGS, 32'h1);
      converter_result <= sst_pkg::CONV_LIMIT;
      measure_start <= 1'b1;
      @(posedge aclk);
      measure_start <= 1'b0;
      range_position_seen <= 1'b1;
      @(posedge aclk);
      range_position_seen <= 1'b0;
      clamp_switch_seen <= 1'b1;
      @(posedge aclk);
      clamp_switch_seen <= 1'b0;
      converter_result <= 16'h0;
      repeat (4) @(posedge aclk);
      chkr(sst_pkg::ADDR_FLAGS, sst_pkg::RESP_OKAY, 32'h0, 32'hfff);
      `CHK("diag", 1'b0, diag_mode)
      fl = 32'h0;
      foreach (fix[i]) begin
         fault(fix[i]);
         fl[fix[i]] = 1'b1;
         chkr(sst_pkg::ADDR_FLAGS, sst_pkg::RESP_OKAY, fl, 32'hfff);
      end
      `CHK("diag", 1'b1, diag_mode)
      wr(sst_pkg::ADDR_CONTROL_ONE, 32'h2);
      repeat (2100) @(posedge aclk);
      chkr(sst_pkg::ADDR_FLAGS, sst_pkg::RESP_OKAY, 32'h80, 32'h80);
      nvm_test_enable <= 5'h1b;
      bad_div <= 1'b1;
      rst();
      repeat (34000) @(posedge aclk);
      `CHK("seen", 5'h1b, seen)
      chkr(sst_pkg::ADDR_SEQ_STATUS, sst_pkg::RESP_OKAY, seq_word(4'h1), 32'h1f);
      chkr(sst_pkg::ADDR_FLAGS, sst_pkg::RESP_OKAY, 32'h0, 32'hfff);
      `CHK("diag", 1'b0, diag_mode)
      nvm_test_enable <= 5'h1f;
      repeat (34000) @(posedge aclk);
      chkr(sst_pkg::ADDR_FLAGS, sst_pkg::RESP_OKAY, 32'h44, 32'hfff);
      `CHK("diag", 1'b1, diag_mode)
      osc_run <= 1'b0;
      ready_off <= 1'b1;
      bad_div <= 1'b0;
      rst();
      repeat (1500) @(posedge aclk);
      chkr(sst_pkg::ADDR_CONTROL_ONE, sst_pkg::RESP_OKAY, 32'h81, 32'h85);
      repeat (3000) @(posedge aclk);
      chkr(sst_pkg::ADDR_CONTROL_ONE, sst_pkg::RESP_OKAY, 32'h85, 32'h85);
      `CHK("diag", 1'b1, diag_mode)
      end_sim();
   end
endmodule
